// ---- rtl/lab_pkg.sv ----
// Shared constants, types and helpers of the line averaging and binning stage.
// Assumes a single pixel clock domain and pixels of fixed width.
`default_nettype none

package lab_pkg;

    localparam int PIX_W      = 12;
    localparam int BIN_W      = PIX_W + 1;
    localparam int OUT_W      = PIX_W + 2;
    localparam int IDX_W      = 13;
    localparam int LINE_DEPTH = 8192;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_W     = OUT_W + 1;

    typedef enum logic [2:0] {
        LAB_SINGLE = 3'h0,
        LAB_VBIN   = 3'h1,
        LAB_TDS_A  = 3'h2,
        LAB_TDS_B  = 3'h3,
        LAB_LAVG   = 3'h4,
        LAB_TDA_A  = 3'h5,
        LAB_TDA_B  = 3'h6
    } lab_mode_t;

    typedef enum logic {
        LAB_BIN_OFF = 1'h0,
        LAB_BIN_ON  = 1'h1
    } lab_bin_t;

    // Two pixels summed one bit wider, so the sum cannot overflow.
    function automatic logic [BIN_W-1:0] lab_pair(
        input logic [PIX_W-1:0] a,
        input logic [PIX_W-1:0] b
    );
        lab_pair = BIN_W'(a) + BIN_W'(b);
    endfunction

    // Halves a sum, rounding odd sums up.
    function automatic logic [OUT_W-1:0] lab_half_up(
        input logic [OUT_W-1:0] s
    );
        lab_half_up = OUT_W'((s + OUT_W'(1)) >> 1);
    endfunction

endpackage

`default_nettype wire

// ---- rtl/lab_stream_if.sv ----
// Valid and ready word stream between the stage and its output buffer.
// Assumes both ends share one clock.
`default_nettype none

interface lab_stream_if #(
    parameter int W = 8
) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// ---- rtl/lab_fifo.sv ----
// First-in first-out buffer with valid and ready on both sides.
// Assumes one clock; nrst is asynchronous and active low.
`default_nettype none

module lab_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input  wire logic   clk,
    input  wire logic   nrst,
    // Filling side and draining side.
    lab_stream_if.snk   inS,
    lab_stream_if.src   outS
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } lab_fifo_st_t;

    lab_fifo_st_t st;
    lab_fifo_st_t next_st;
    logic [W-1:0] mem [0:DEPTH-1];
    logic         full;
    logic         empty;
    logic         push;
    logic         pop;

    assign full  = (st.wr[AW] != st.rd[AW]) &&
                   (st.wr[AW-1:0] == st.rd[AW-1:0]);
    assign empty = st.wr == st.rd;
    assign inS.ready  = !full;
    assign outS.valid = !empty;
    assign outS.data  = mem[st.rd[AW-1:0]];
    assign push = inS.valid && !full;
    assign pop  = outS.ready && !empty;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wr = st.wr + (AW+1)'(1);
        end
        if (pop) begin
            next_st.rd = st.rd + (AW+1)'(1);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[st.wr[AW-1:0]] <= inS.data;
        end
    end

    fifo_level_a: assert property (@(posedge clk) disable iff (!nrst)
        (st.wr - st.rd) <= (AW+1)'(DEPTH))
        else $error("Buffer level exceeds its depth.");

    fifo_full_a: assert property (@(posedge clk) disable iff (!nrst)
        full && !pop |=> full && $stable(st.wr))
        else $error("Full buffer accepted a word.");

    fifo_full_c: cover property (@(posedge clk) disable iff (!nrst) full);

endmodule // lab_fifo

`default_nettype wire

// ---- rtl/lab_line_combiner.sv ----
// Pixel combining stage: pair binning, line averaging and delayed combining.
// Assumes sensor pixels of lines A and B arrive side by side, one pair per
// accepted cycle, with senLast on the line's final pixel; all inputs are
// synchronous to clk and configuration is stable within a line.
// Notes on behaviour
// - Delayed averaging halves the sum, rounding up.
// - Separate mode codes delay line A or B.
// - Delayed line buffered, combined on next acquisition.
// - Combined result leaves as one ordinary line.
// - Binning is independent of the acquisition mode.
// - Binning sums non-overlapping adjacent pixel pairs.
// - Line A and B binned separately, before combining.
// - Single mode with binning uses line A only.
// - Binning halves the pixels per line.
// - Area of interest counts binned pixels.
// - Binning plus vertical binning sums two-by-two.
// - Binning follows the binning mode field.
// - Binning halves buffer load, so never lowers line rate.
`default_nettype none

module lab_line_combiner (
    // Clock and reset.
    input  wire logic                        clk,
    input  wire logic                        nrst,
    // Configuration.
    input  wire lab_pkg::lab_mode_t          lineMode,
    input  wire lab_pkg::lab_bin_t           binMode,
    input  wire logic [lab_pkg::IDX_W-1:0]   aoiStart,
    input  wire logic [lab_pkg::IDX_W-1:0]   aoiWidth,
    // Sensor readout.
    input  wire logic                        senValid,
    output logic                             senReady,
    input  wire logic [lab_pkg::PIX_W-1:0]   senPixA,
    input  wire logic [lab_pkg::PIX_W-1:0]   senPixB,
    input  wire logic                        senLast,
    // Stream to the frame grabber.
    output logic                             outValid,
    input  wire logic                        outReady,
    output logic [lab_pkg::OUT_W-1:0]        outPix,
    output logic                             outLast
);
    import lab_pkg::*;

    typedef struct packed {
        logic             binPhase;
        logic [PIX_W-1:0] heldA;
        logic [PIX_W-1:0] heldB;
        logic [IDX_W-1:0] outIdx;
    } lab_comb_st_t;

    lab_comb_st_t     st;
    lab_comb_st_t     next_st;
    logic [BIN_W-1:0] lineBuf [0:LINE_DEPTH-1];

    lab_stream_if #(.W(FIFO_W)) pushIf ();
    lab_stream_if #(.W(FIFO_W)) popIf ();

    logic             binOn;
    logic             accept;
    logic             produce;
    logic             delayed;
    logic             inAoi;
    logic             aoiEnd;
    logic [BIN_W-1:0] sA;
    logic [BIN_W-1:0] sB;
    logic [BIN_W-1:0] dly;
    logic [BIN_W-1:0] storeVal;
    logic [OUT_W-1:0] result;
    logic [IDX_W:0]   aoiLim;

    assign binOn   = binMode == LAB_BIN_ON;
    // A stalled output buffer holds off the sensor readout.
    assign senReady = pushIf.ready;
    assign accept  = senValid && senReady;
    // With binning, only the second pixel of a pair yields a result.
    assign produce = !binOn || st.binPhase;

    // Each sensor line is binned on its own before any line combining.
    always_comb begin
        if (binOn) begin
            sA = lab_pair(st.heldA, senPixA);
            sB = lab_pair(st.heldB, senPixB);
        end else begin
            sA = BIN_W'(senPixA);
            sB = BIN_W'(senPixB);
        end
    end

    assign dly = lineBuf[st.outIdx];
    assign delayed = (lineMode == LAB_TDS_A) || (lineMode == LAB_TDS_B) ||
                     (lineMode == LAB_TDA_A) || (lineMode == LAB_TDA_B);

    always_comb begin
        storeVal = sA;
        case (lineMode)
            LAB_SINGLE: result = OUT_W'(sA);
            LAB_VBIN:   result = OUT_W'(sA) + OUT_W'(sB);
            LAB_LAVG:   result = lab_half_up(OUT_W'(sA) + OUT_W'(sB));
            LAB_TDS_A:  result = OUT_W'(dly) + OUT_W'(sB);
            LAB_TDS_B: begin
                result   = OUT_W'(dly) + OUT_W'(sA);
                storeVal = sB;
            end
            LAB_TDA_A:  result = lab_half_up(OUT_W'(dly) + OUT_W'(sB));
            LAB_TDA_B: begin
                result   = lab_half_up(OUT_W'(dly) + OUT_W'(sA));
                storeVal = sB;
            end
            default:    result = OUT_W'(sA);
        endcase
    end

    // Window positions count output pixels, so binned pixels when binning.
    assign aoiLim = (IDX_W+1)'(aoiStart) + (IDX_W+1)'(aoiWidth);
    assign inAoi  = (st.outIdx >= aoiStart) &&
                    ((IDX_W+1)'(st.outIdx) < aoiLim);
    assign aoiEnd = (IDX_W+1)'(st.outIdx) + (IDX_W+1)'(1) == aoiLim;

    // Results carry a last-pixel flag so each line frames like a plain line.
    assign pushIf.valid = senValid && produce && inAoi;
    assign pushIf.data  = {aoiEnd, result};

    always_comb begin
        next_st = st;
        if (accept) begin
            if (binOn && !st.binPhase && !senLast) begin
                next_st.binPhase = 1'b1;
                next_st.heldA    = senPixA;
                next_st.heldB    = senPixB;
            end else begin
                next_st.binPhase = 1'b0;
                if (senLast) begin
                    next_st.outIdx = '0;
                end else if (produce) begin
                    next_st.outIdx = st.outIdx + IDX_W'(1);
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // The delayed line is kept for the next acquisition; old value read first.
    always_ff @(posedge clk) begin
        if (accept && produce && delayed) begin
            lineBuf[st.outIdx] <= storeVal;
        end
    end

    lab_fifo #(
        .W     (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk  (clk),
        .nrst (nrst),
        .inS  (pushIf),
        .outS (popIf)
    );

    assign outValid    = popIf.valid;
    assign popIf.ready = outReady;
    assign outPix      = popIf.data[OUT_W-1:0];
    assign outLast     = popIf.data[OUT_W];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    bin_first_a: assert property (
        accept && binOn && !st.binPhase && !senLast
        |-> !pushIf.valid ##1 st.binPhase && st.heldA == $past(senPixA))
        else $error("First pixel of a pair was not held.");

    bin_half_a: assert property (
        accept && binOn && st.binPhase && !senLast
        |=> !st.binPhase && st.outIdx == $past(st.outIdx) + IDX_W'(1))
        else $error("Binned index did not advance once per pair.");

    single_lineA_a: assert property (
        pushIf.valid && lineMode == LAB_SINGLE && binOn
        |-> result == OUT_W'(st.heldA) + OUT_W'(senPixA))
        else $error("Single mode result is not the line A pair sum.");

    avg_round_a: assert property (
        pushIf.valid && lineMode == LAB_TDA_A
        |-> {result, 1'b0} >= (OUT_W+1)'(dly) + (OUT_W+1)'(sB) &&
            {result, 1'b0} <= (OUT_W+1)'(dly) + (OUT_W+1)'(sB) + 15'h0001)
        else $error("Delayed average is not the rounded-up half.");

    line_store_a: assert property (
        accept && produce && lineMode == LAB_TDS_B
        |=> lineBuf[$past(st.outIdx)] == $past(sB))
        else $error("Delayed line B was not buffered.");

    line_end_a: assert property (
        accept && senLast |=> st.outIdx == '0 && !st.binPhase)
        else $error("Line end did not restart the pixel index.");

    aoi_window_a: assert property (
        pushIf.valid |-> st.outIdx >= aoiStart &&
                         (IDX_W+1)'(st.outIdx) < aoiLim)
        else $error("Pixel outside the window was sent.");

    stall_a: assert property (
        senValid && !senReady |-> outValid ##1 st == $past(st))
        else $error("Refused sensor pair changed the stage state.");

    bin_pair_c: cover property (accept && binOn && st.binPhase);
    delayed_c:  cover property (pushIf.valid && lineMode == LAB_TDA_B);
    vbin_c:     cover property (pushIf.valid && lineMode == LAB_VBIN && binOn);
    line_c:     cover property (outValid && outReady && outLast);

endmodule // lab_line_combiner

`default_nettype wire

// ---- test/lab_grabber_model.sv ----
// Frame grabber model that takes the stage's output stream and keeps it.
// Assumes one clock shared with the stage; stall holds ready low.
`default_nettype none

module lab_grabber_model
    import lab_pkg::*;
(
    // Clock and reset.
    input  wire logic                    clk,
    input  wire logic                    nrst,
    // Pacing from the bench.
    input  wire logic                    stall,
    input  wire logic                    slow,
    // Stream from the stage.
    input  wire logic                    outValid,
    output logic                         outReady,
    input  wire logic [lab_pkg::OUT_W-1:0] outPix,
    input  wire logic                    outLast
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [OUT_W:0] got[$];

    // Ready moves just after an edge; a slow grabber takes every other cycle.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            outReady <= 1'b0;
        end else begin
            outReady <= !stall && !(slow && outReady);
            if (outValid && outReady) begin
                got.push_back({outLast, outPix});
            end
        end
    end
endmodule // lab_grabber_model

`default_nettype wire

// ---- test/lab_line_combiner_tb.sv ----
// Bench for the line combining stage with a grabber model on its output.
// Assumes the package, the stage and the grabber model are compiled first.
`default_nettype none

module lab_line_combiner_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import lab_pkg::*;
    logic             clk = 1'b0, nrst = 1'b0, senValid = 1'b0, senLast = 1'b0;
    logic             stall = 1'b0, slow = 1'b0, senReady, outValid, outReady;
    logic             outLast;
    lab_mode_t        lineMode = LAB_SINGLE;
    lab_bin_t         binMode = LAB_BIN_OFF;
    logic [IDX_W-1:0] aoiStart = '0, aoiWidth = '0;
    logic [PIX_W-1:0] senPixA = '0, senPixB = '0;
    logic [OUT_W-1:0] outPix;
    logic [PIX_W-1:0] pa[32], pb[32], qa[32], qb[32];
    int               mismatches = 0, comparisons = 0, cycles = 0;

    lab_line_combiner u_lab_line_combiner (.clk(clk), .nrst(nrst),
        .lineMode(lineMode), .binMode(binMode), .aoiStart(aoiStart),
        .aoiWidth(aoiWidth), .senValid(senValid), .senReady(senReady),
        .senPixA(senPixA), .senPixB(senPixB), .senLast(senLast),
        .outValid(outValid), .outReady(outReady), .outPix(outPix),
        .outLast(outLast));
    lab_grabber_model u_lab_grabber_model (.clk(clk), .nrst(nrst),
        .stall(stall), .slow(slow), .outValid(outValid),
        .outReady(outReady), .outPix(outPix), .outLast(outLast));

    initial begin
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            close_out();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One output pixel of line A or B, current or previous, binned or not.
    function automatic logic [OUT_W-1:0] val(input bit useB, input bit prv,
                                             input int k, input bit bin);
        logic [PIX_W-1:0] x, y;
        int               j;
        j = bin ? 2 * k : k;
        x = prv ? (useB ? qb[j] : qa[j]) : (useB ? pb[j] : pa[j]);
        y = prv ? (useB ? qb[j+1] : qa[j+1]) : (useB ? pb[j+1] : pa[j+1]);
        return bin ? OUT_W'(x) + OUT_W'(y) : OUT_W'(x);
    endfunction

    function automatic logic [OUT_W-1:0] exp_pix(input lab_mode_t m,
                                                 input bit bin, input int k);
        logic [OUT_W-1:0] a, b, da, db;
        a = val(0, 0, k, bin);
        b = val(1, 0, k, bin);
        da = val(0, 1, k, bin);
        db = val(1, 1, k, bin);
        case (m)
            LAB_VBIN:  return a + b;
            LAB_TDS_A: return da + b;
            LAB_TDS_B: return db + a;
            LAB_LAVG:  return OUT_W'((a + b + 1) >> 1);
            LAB_TDA_A: return OUT_W'((da + b + 1) >> 1);
            LAB_TDA_B: return OUT_W'((db + a + 1) >> 1);
            default:   return a;
        endcase
    endfunction

    // Sends one line of n pairs, then checks the window that comes out.
    task automatic send_line(input lab_mode_t m, input bit bin, input int s,
                             input int n, input int st, input int w,
                             input bit chk);
        int outN;
        int k;
        @(negedge clk);
        lineMode = m;
        binMode = bin ? LAB_BIN_ON : LAB_BIN_OFF;
        aoiStart = IDX_W'(st);
        aoiWidth = IDX_W'(w);
        for (k = 0; k < 32; k++) begin
            qa[k] = pa[k];
            qb[k] = pb[k];
            pa[k] = (s != 0) ? PIX_W'(s * 37 + k * 411) : 12'hfff;
            pb[k] = (s != 0) ? PIX_W'(s * 53 + k * 97 + 1) : 12'hfff;
        end
        for (k = 0; k < n; k++) begin
            senValid = 1'b1;
            senPixA = pa[k];
            senPixB = pb[k];
            senLast = (k == n - 1);
            while (senReady !== 1'b1) @(negedge clk);
            @(negedge clk);
        end
        senValid = 1'b0;
        senLast = 1'b0;
        outN = bin ? n / 2 : n;
        outN = ((outN > st + w) ? st + w : outN) - st;
        for (k = 0; k < 300; k++) begin
            if (u_lab_grabber_model.got.size() >= outN) break;
            @(negedge clk);
        end
        repeat (4) @(negedge clk);
        if (chk) begin
            check(u_lab_grabber_model.got.size(), outN);
            for (k = 0; k < outN; k++) begin
                check(u_lab_grabber_model.got[k], {k == w - 1,
                      exp_pix(m, bin, k + st)});
            end
        end
        u_lab_grabber_model.got.delete();
    endtask

    task automatic t_delayed();
        int codes[4] = '{2, 3, 5, 6};
        lab_mode_t m;
        for (int i = 0; i < 4; i++) begin
            m = lab_mode_t'(codes[i]);
            for (int b = 0; b < 2; b++) begin
                // The first line plays the line that the image crosses first.
                send_line(m, b, 3 + i, 16, 0, 16, 0);
                send_line(m, b, 9 + i, 16, 0, 16, 1);
            end
        end
    endtask

    task automatic t_single_bin();
        send_line(LAB_SINGLE, 1, 7, 11, 1, 3, 1);
        send_line(LAB_SINGLE, 1, 8, 32, 0, 16, 1);
        send_line(LAB_LAVG, 1, 4, 12, 0, 6, 1);
    endtask

    task automatic t_vbin_max();
        send_line(LAB_VBIN, 1, 0, 8, 0, 4, 1);
        send_line(LAB_LAVG, 0, 5, 8, 0, 8, 1);
        send_line(lab_mode_t'(3'h7), 0, 2, 8, 0, 8, 1);
    endtask

    task automatic t_backpressure();
        stall = 1'b1;
        fork
            send_line(LAB_SINGLE, 0, 6, 24, 0, 24, 1);
            begin
                repeat (30) @(negedge clk);
                check(32'(senReady), 32'h0000_0000);
                stall = 1'b0;
                slow = 1'b1;
            end
        join
        slow = 1'b0;
    endtask

    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        t_delayed();
        t_single_bin();
        t_vbin_max();
        t_backpressure();
        close_out();
    end
endmodule // lab_line_combiner_tb

`default_nettype wire
